// ---- tb/dprw_port_checker.sv ----
/*
 * Concurrent checks on the debug port top ports.
 * Assumes it is bound to dprw_port, one core clock, active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module dprw_port_checker (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire dprw_pkg::dprw_reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire dprw_pkg::dprw_mem_req_t MEM_REQ,
    input wire logic MEM_REFUSED,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic [23:0] BUS_ADDR,
    input wire logic [7:0] BUS_WDATA,
    input wire logic BUS_READY,
    input wire logic MEM_DONE,
    input wire logic ROW_COPY_START,
    input wire logic SYNC_PIN,
    input wire logic SYNC_EVENT,
    input wire logic SYS_ASLEEP,
    input wire logic SYS_CLK_STOPPED,
    input wire logic SYS_CLK_REQ,
    input wire logic SYS_RESET_REQ,
    input wire logic SLEEP_EMULATE
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    chk_reset_cause: assert property ($rose(SYS_RESET_REQ) |-> $past(REG_REQ.wr)
        && $past(REG_REQ.addr) == dprw_pkg::OFS_RST_REQ
        && $past(REG_REQ.wdata) == dprw_pkg::RST_SIGNATURE) else $error("reset without signature");
    chk_stopped_refuse: assert property ((MEM_REQ.wr || MEM_REQ.rd) && SYS_CLK_STOPPED
        && !SLEEP_EMULATE |-> MEM_REFUSED) else $error("access with clock stopped");
    chk_refused_nobus: assert property (MEM_REFUSED |=> !$rose(BUS_WR)
        && !$rose(BUS_RD)) else $error("refused request reached bus");
    chk_bus_hold: assert property ((BUS_WR || BUS_RD) && !BUS_READY |=> (BUS_WR || BUS_RD)
        && $stable(BUS_ADDR) && $stable(BUS_WDATA)) else $error("bus request dropped");
    chk_mem_done: assert property ((BUS_WR || BUS_RD) && BUS_READY |=> MEM_DONE
        && !BUS_WR && !BUS_RD) else $error("no completion after ready");
    chk_copy_cause: assert property (ROW_COPY_START |-> $past(REG_REQ.wr)
        && $past(REG_REQ.addr) == dprw_pkg::OFS_SESS_CTRL
        && $past(REG_REQ.wdata[dprw_pkg::SESS_DONE_BIT])) else $error("copy without done write");
    chk_sync_event: assert property ($rose(SYNC_PIN) |-> ##[3:7] SYNC_EVENT)
        else $error("sync edge gave no event");
    chk_asleep_read: assert property (REG_REQ.rd && REG_REQ.addr == dprw_pkg::OFS_SYS_FLAGS
        |=> REG_RDATA[dprw_pkg::SYS_ASLEEP_BIT] == $past(SYS_ASLEEP)) else $error("asleep flag wrong");
    chk_emulate_req: assert property ($rose(SYS_CLK_REQ) |-> SLEEP_EMULATE)
        else $error("clock hold not set on enable");
endmodule
`default_nettype wire

// ---- tb/dprw_port_tb.sv ----
/*
 * Self-checking bench for the debug port access layer: register calls,
 * key shifting, row-write session, sleep refusal and sync events.
 * Assumes the system model and the checker files are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module dprw_port_tb;
    // ************************************************************
    // Stimulus, tasks and sequence
    // ************************************************************
    logic CORE_CLK = 1'b0, RSTN = 1'b0, KEY_BIT_VALID = 1'b0, KEY_BIT = 1'b0, KEY_END = 1'b0;
    logic SYNC_PIN = 1'b0, SYS_ASLEEP = 1'b0, SYS_CLK_STOPPED = 1'b0;
    dprw_pkg::dprw_reg_req_t REG_REQ = '0;
    dprw_pkg::dprw_mem_req_t MEM_REQ = '0;
    logic [7:0] REG_RDATA, MEM_RDATA, BUS_WDATA, BUS_RDATA, PHY_CTRL_PRI, PHY_CLK_DIV, d;
    logic MEM_REFUSED, BUS_WR, BUS_RD, BUS_READY, MEM_DONE, ROW_COPY_START, ROW_COPY_DONE;
    logic SYNC_EVENT, SYS_CLK_REQ, SYS_RESET_REQ, SLEEP_EMULATE;
    logic [23:0] BUS_ADDR;
    int err_total = 0, check_count = 0, sync_seen = 0, copy_seen = 0;
    logic [3:0] ofs [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hA, 4'h4};
    logic [7:0] rst_val [9] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h00};

    dprw_port dut (.CORE_CLK, .RSTN, .REG_REQ, .REG_RDATA, .KEY_BIT_VALID, .KEY_BIT, .KEY_END,
        .MEM_REQ, .MEM_REFUSED, .BUS_WR, .BUS_RD, .BUS_ADDR, .BUS_WDATA, .BUS_READY, .BUS_RDATA,
        .MEM_RDATA, .MEM_DONE, .ROW_COPY_START, .ROW_COPY_DONE, .SYNC_PIN, .SYNC_EVENT,
        .SYS_ASLEEP, .SYS_CLK_STOPPED, .SYS_CLK_REQ, .SYS_RESET_REQ, .SLEEP_EMULATE,
        .PHY_CTRL_PRI, .PHY_CLK_DIV, .PHY_ERR_SIG(3'h0), .PHY_ERR_SET(1'b0),
        .SYS_FLAGS_OTHER(8'h00));
    dprw_sys_model sys (.clk(CORE_CLK), .rst_n(RSTN), .bus_wr(BUS_WR), .bus_rd(BUS_RD),
        .bus_addr(BUS_ADDR), .bus_wdata(BUS_WDATA), .bus_ready(BUS_READY),
        .bus_rdata(BUS_RDATA), .copy_start(ROW_COPY_START), .copy_done(ROW_COPY_DONE));

    // Clock and event counters
    always #5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        sync_seen += (SYNC_EVENT === 1'b1);
        copy_seen += (ROW_COPY_START === 1'b1);
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge CORE_CLK) #1 REG_REQ = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge CORE_CLK) #1 REG_REQ = '0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge CORE_CLK) #1 REG_REQ = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge CORE_CLK) #1 REG_REQ = '0;
        d = REG_RDATA;
        if (m != 8'h00) chk(d & m, e, "register read");
    endtask
    task automatic poll_start(input logic [7:0] e);
        d = ~e;
        for (int n = 0; n < 30 && (d & 8'h04) !== e; n++) rd_chk(4'hB, 8'h00, 8'h00);
        chk(d & 8'h04, e, "start flag");
    endtask
    task automatic mem(input logic w, input logic [23:0] a, input logic [7:0] v, input logic r);
        @(posedge CORE_CLK) #1 MEM_REQ = '{wr: w, rd: !w, addr: a, wdata: v};
        #1 chk({7'h00, MEM_REFUSED}, {7'h00, r}, "refusal");
        @(posedge CORE_CLK) #1 MEM_REQ = '0;
        for (int n = 0; n < 40 && !r && MEM_DONE !== 1'b1; n++) @(posedge CORE_CLK) #1;
        if (!r) chk({7'h00, MEM_DONE}, 8'h01, "memory completion");
        d = MEM_RDATA;
    endtask
    task automatic key_send(input logic [63:0] k, input int nb);
        for (int i = 0; i < nb; i++) begin
            @(posedge CORE_CLK) #1 KEY_BIT_VALID = 1'b1;
            KEY_BIT = k[i];
        end
        @(posedge CORE_CLK) #1 KEY_BIT_VALID = 1'b0;
        KEY_END = 1'b1;
        @(posedge CORE_CLK) #1 KEY_END = 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #100000;
        err_total++;
        $display("mismatch at %0t: run did not finish", $time);
        test_done();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge CORE_CLK);
        #1 RSTN = 1'b1;
        for (int i = 0; i < 9; i++) rd_chk(ofs[i], 8'hFF, rst_val[i]);
        chk({6'h00, SYS_CLK_REQ, SLEEP_EMULATE}, 8'h03, "outputs after reset");
        reg_wr(4'h2, 8'hFF);
        rd_chk(4'h2, 8'hFF, 8'hBF);
        reg_wr(4'h9, 8'hFF);
        rd_chk(4'h9, 8'hFF, 8'h03);
        chk(PHY_CTRL_PRI ^ PHY_CLK_DIV, 8'hBC, "phy configuration");
        SYS_ASLEEP = 1'b1;
        rd_chk(4'hB, 8'h10, 8'h10);
        SYS_ASLEEP = 1'b0;
        rd_chk(4'hB, 8'h10, 8'h00);
        reg_wr(4'hA, 8'h03);
        key_send(dprw_pkg::ROW_KEY, 63);
        rd_chk(4'h7, 8'h20, 8'h00);
        key_send(dprw_pkg::ROW_KEY, 64);
        rd_chk(4'h7, 8'h20, 8'h20);
        reg_wr(4'h8, dprw_pkg::RST_SIGNATURE);
        chk({7'h00, SYS_RESET_REQ}, 8'h01, "reset raised");
        reg_wr(4'h8, dprw_pkg::RST_RUN);
        chk({7'h00, SYS_RESET_REQ}, 8'h00, "reset released");
        poll_start(8'h04);
        mem(1'b1, 24'h0001FF, 8'hA5, 1'b0);
        mem(1'b1, 24'h000200, 8'h5A, 1'b1);
        mem(1'b0, 24'h0001FF, 8'h00, 1'b1);
        chk(copy_seen[7:0], 8'h00, "early done ignored");
        reg_wr(4'hA, 8'h03);
        poll_start(8'h00);
        chk(sys.row[511], 8'hA5, "row contents");
        chk(copy_seen[7:0], 8'h01, "one copy");
        reg_wr(4'h7, 8'h20);
        rd_chk(4'h7, 8'h20, 8'h00);
        reg_wr(4'h8, dprw_pkg::RST_SIGNATURE);
        reg_wr(4'h8, dprw_pkg::RST_RUN);
        reg_wr(4'h8, 8'h5A);
        chk({7'h00, SYS_RESET_REQ}, 8'h00, "reserved value");
        mem(1'b0, 24'h0001FF, 8'h00, 1'b0);
        chk(d, 8'hA5, "read back after session");
        reg_wr(4'hA, 8'h00);
        SYS_CLK_STOPPED = 1'b1;
        mem(1'b0, 24'h000010, 8'h00, 1'b1);
        reg_wr(4'hA, 8'h01);
        mem(1'b1, 24'h000010, 8'h3C, 1'b0);
        SYS_CLK_STOPPED = 1'b0;
        reg_wr(4'h3, 8'h04);
        chk({7'h00, SYS_CLK_REQ}, 8'h00, "clock request off");
        for (int i = 0; i < 6; i++) begin
            repeat (8) @(posedge CORE_CLK);
            #1 SYNC_PIN = ~SYNC_PIN;
        end
        repeat (10) @(posedge CORE_CLK);
        chk(sync_seen[7:0], 8'h03, "sync events");
        reg_wr(4'h3, 8'h00);
        rd_chk(4'hA, 8'h01, 8'h01);
        chk({7'h00, SYS_CLK_REQ}, 8'h01, "clock request on");
        test_done();
    end
endmodule

bind dprw_port dprw_port_checker chk (.CORE_CLK, .RSTN, .REG_REQ, .REG_RDATA, .MEM_REQ,
    .MEM_REFUSED, .BUS_WR, .BUS_RD, .BUS_ADDR, .BUS_WDATA, .BUS_READY, .MEM_DONE,
    .ROW_COPY_START, .SYNC_PIN, .SYNC_EVENT, .SYS_ASLEEP, .SYS_CLK_STOPPED, .SYS_CLK_REQ,
    .SYS_RESET_REQ, .SLEEP_EMULATE);
`default_nettype wire

// ---- tb/dprw_sys_model.sv ----
/*
 * System side model: answers held bus requests after a fixed wait, keeps
 * the RAM staging area and copies it into the configuration row.
 * Assumes the debug port core clock and its active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module dprw_sys_model #(
    parameter int READY_WAIT = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [23:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output var logic bus_ready,
    output var logic [7:0] bus_rdata,
    input wire logic copy_start,
    output var logic copy_done
);
    // ************************************************************
    // Storage and answers
    // ************************************************************
    logic [7:0] ram [0:511];
    logic [7:0] row [0:511];
    int wait_cnt;
    int copy_cnt;

    // Bus answer; read data toggles whenever it is not valid
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ready <= 1'b0;
            wait_cnt <= 0;
            bus_rdata <= 8'h00;
        end else if (bus_ready) begin
            bus_ready <= 1'b0;
            bus_rdata <= ~bus_rdata;
            if (bus_wr && bus_addr < 24'h000200) begin
                ram[bus_addr[8:0]] <= bus_wdata;
            end
        end else if ((bus_wr || bus_rd) && wait_cnt == READY_WAIT) begin
            bus_ready <= 1'b1;
            wait_cnt <= 0;
            bus_rdata <= ram[bus_addr[8:0]];
        end else begin
            wait_cnt <= (bus_wr || bus_rd) ? wait_cnt + 1 : 0;
            bus_rdata <= ~bus_rdata;
        end
    end

    // Row copy, offset for offset, then a late completion pulse
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            copy_done <= 1'b0;
            copy_cnt <= 0;
        end else begin
            copy_done <= (copy_cnt == 1);
            if (copy_start) begin
                copy_cnt <= 4;
                for (int i = 0; i < 512; i++) begin
                    row[i] <= ram[i];
                end
            end else if (copy_cnt != 0) begin
                copy_cnt <= copy_cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verilog/dprw_pkg.sv ----
/*
 * Constants, field positions and carrier types for the debug port access layer
 * (row-write session, sync event, sleep and clock hold).
 * Assumes the physical layer delivers decoded register and RAM accesses.
 */
package dprw_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [3:0] OFS_REVISION = 4'h0;
    localparam logic [3:0] OFS_ERRSIG = 4'h1;
    localparam logic [3:0] OFS_CTRL_PRI = 4'h2;
    localparam logic [3:0] OFS_CTRL_SEC = 4'h3;
    localparam logic [3:0] OFS_KEY_FLAGS = 4'h7;
    localparam logic [3:0] OFS_RST_REQ = 4'h8;
    localparam logic [3:0] OFS_CLK_DIV = 4'h9;
    localparam logic [3:0] OFS_SESS_CTRL = 4'hA;
    localparam logic [3:0] OFS_SYS_FLAGS = 4'hB;
    localparam logic [3:0] OFS_SCAN = 4'hC;

    // ************************************************************
    // Field positions and values
    // ************************************************************
    localparam int KEY_ROW_BIT = 5;
    localparam int SYS_ASLEEP_BIT = 4;
    localparam int SYS_ROWSTART_BIT = 2;
    localparam int SESS_DONE_BIT = 1;
    localparam int SESS_CLKHOLD_BIT = 0;
    localparam int SEC_DISABLE_BIT = 2;
    localparam logic [7:0] RST_SIGNATURE = 8'h59;
    localparam logic [7:0] RST_RUN = 8'h00;
    localparam logic [7:0] REVISION_RESET = 8'h10;
    localparam logic [7:0] CLK_DIV_RESET = 8'h03;
    localparam logic [7:0] CTRL_PRI_MASK = 8'hBF;
    localparam logic [7:0] CTRL_SEC_MASK = 8'h1C;
    localparam logic [7:0] CLK_DIV_MASK = 8'h03;
    localparam logic [63:0] ROW_KEY = 64'h4E564D5573267465;
    localparam int ROW_BYTES = 512;
    localparam int KEY_BITS = 64;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dprw_reg_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [23:0] addr;
        logic [7:0] wdata;
    } dprw_mem_req_t;

endpackage

// ---- verilog/dprw_port.sv ----
/*
 * Access layer of the single-wire debug port: register file, row-write key
 * session with RAM staging and row copy, sync event, sleep handling.
 * Assumes the physical layer hands over decoded one-cycle requests, and the
 * system side answers bus handshakes and copy completion.
 */
// Function
// - Key flags register exposes a row-write key flag readable by debugger.
// - Device sets row start flag when ready; debugger waits until it reads one.
// - During session, RAM writes beyond first 512 bytes are dropped.
// - On completion staged RAM is copied one-to-one into the config row.
// - Device clears row start flag when copy ends; debugger polls for zero.
// - In row-write mode all RAM reads are refused; only low writes pass.
// - Sync event level pulses on each rising sync edge; never disabled.
// - Port consumes no routed events; it only generates one.
// - Physical-layer logic keeps running in every sleep mode.
// - No system bus access while the system clock is stopped, unless clock hold emulates sleep.
// - When enabled the port requests the system clock.
// - Read-only asleep flag reports whether the system domain sleeps.
// - Clock hold keeps system clock through sleep, sleep only emulated.
// - Clock hold bit reads one by default whenever the port is enabled.
// - Only 0x59 requests reset, 0x00 releases, port itself not reset.
// - Device sets key flag on decode; debugger write to it ends session.
`timescale 1ns/10ps
`default_nettype none
module dprw_port #(
    parameter int ROW_SIZE = dprw_pkg::ROW_BYTES,
    parameter int ADDR_W = 24
) (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire dprw_pkg::dprw_reg_req_t REG_REQ,
    output var logic [7:0] REG_RDATA,
    input wire logic KEY_BIT_VALID,
    input wire logic KEY_BIT,
    input wire logic KEY_END,
    input wire dprw_pkg::dprw_mem_req_t MEM_REQ,
    output logic MEM_REFUSED,
    output var logic BUS_WR,
    output var logic BUS_RD,
    output var logic [23:0] BUS_ADDR,
    output var logic [7:0] BUS_WDATA,
    input wire logic BUS_READY,
    input wire logic [7:0] BUS_RDATA,
    output var logic [7:0] MEM_RDATA,
    output var logic MEM_DONE,
    output var logic ROW_COPY_START,
    input wire logic ROW_COPY_DONE,
    input wire logic SYNC_PIN,
    output var logic SYNC_EVENT,
    input wire logic SYS_ASLEEP,
    input wire logic SYS_CLK_STOPPED,
    output logic SYS_CLK_REQ,
    output logic SYS_RESET_REQ,
    output logic SLEEP_EMULATE,
    output logic [7:0] PHY_CTRL_PRI,
    output logic [7:0] PHY_CLK_DIV,
    input wire logic [2:0] PHY_ERR_SIG,
    input wire logic PHY_ERR_SET,
    input wire logic [7:0] SYS_FLAGS_OTHER
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic reg_hit(input dprw_pkg::dprw_reg_req_t r, input logic [3:0] ofs);
        reg_hit = r.addr == ofs;
    endfunction

    typedef enum logic [1:0] {DPRW_IDLE, DPRW_STAGE, DPRW_COPY} dprw_state_t;

    dprw_state_t state_reg;
    logic [7:0] ctrl_pri_reg;
    logic [7:0] ctrl_sec_reg;
    logic [7:0] rst_req_reg;
    logic [7:0] clk_div_reg;
    logic clk_hold_reg;
    logic key_flag_reg;
    logic [2:0] err_sig_reg;
    localparam int KEY_BITS_W = dprw_pkg::KEY_BITS;
    logic [KEY_BITS_W-1:0] key_shift_reg;
    logic [6:0] key_cnt_reg;
    logic reset_seen_reg;
    logic sync_q;
    logic sync_prev_reg;
    logic bus_busy_reg;
    logic port_enabled;
    logic row_start;
    logic in_session;
    logic row_ok;
    logic key_close_wr;
    logic done_wr;

    assign port_enabled = !ctrl_sec_reg[dprw_pkg::SEC_DISABLE_BIT];
    assign row_start = in_session;
    assign in_session = state_reg != DPRW_IDLE;
    assign row_ok = MEM_REQ.addr < ADDR_W'(ROW_SIZE);
    assign key_close_wr = REG_REQ.wr && reg_hit(REG_REQ, dprw_pkg::OFS_KEY_FLAGS)
        && REG_REQ.wdata[dprw_pkg::KEY_ROW_BIT];
    assign done_wr = REG_REQ.wr && reg_hit(REG_REQ, dprw_pkg::OFS_SESS_CTRL)
        && REG_REQ.wdata[dprw_pkg::SESS_DONE_BIT];

    // ************************************************************
    // Plain control registers
    // ************************************************************
    // Link control, divider and reset request; reset request never resets the port
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_pri_reg <= 8'h00;
            ctrl_sec_reg <= 8'h00;
            rst_req_reg <= dprw_pkg::RST_RUN;
            clk_div_reg <= dprw_pkg::CLK_DIV_RESET;
        end else if (REG_REQ.wr) begin
            if (reg_hit(REG_REQ, dprw_pkg::OFS_CTRL_PRI)) begin
                ctrl_pri_reg <= REG_REQ.wdata & dprw_pkg::CTRL_PRI_MASK;
            end
            if (reg_hit(REG_REQ, dprw_pkg::OFS_CTRL_SEC)) begin
                ctrl_sec_reg <= REG_REQ.wdata & dprw_pkg::CTRL_SEC_MASK;
            end
            if (reg_hit(REG_REQ, dprw_pkg::OFS_RST_REQ) && port_enabled) begin
                rst_req_reg <= REG_REQ.wdata;
            end
            if (reg_hit(REG_REQ, dprw_pkg::OFS_CLK_DIV)) begin
                clk_div_reg <= REG_REQ.wdata & dprw_pkg::CLK_DIV_MASK;
            end
        end
    end

    assign SYS_RESET_REQ = rst_req_reg == dprw_pkg::RST_SIGNATURE;
    assign PHY_CTRL_PRI = ctrl_pri_reg;
    assign PHY_CLK_DIV = clk_div_reg;

    // Clock hold; back to one whenever the port is disabled so it reads one on enable
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            clk_hold_reg <= 1'b1;
        end else if (!port_enabled) begin
            clk_hold_reg <= 1'b1;
        end else if (REG_REQ.wr && reg_hit(REG_REQ, dprw_pkg::OFS_SESS_CTRL)) begin
            clk_hold_reg <= REG_REQ.wdata[dprw_pkg::SESS_CLKHOLD_BIT];
        end
    end

    assign SYS_CLK_REQ = port_enabled;
    assign SLEEP_EMULATE = port_enabled && clk_hold_reg;

    // Error signature: set by the link, cleared by a read; a new error wins
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            err_sig_reg <= 3'h0;
        end else if (PHY_ERR_SET) begin
            err_sig_reg <= PHY_ERR_SIG;
        end else if (REG_REQ.rd && reg_hit(REG_REQ, dprw_pkg::OFS_ERRSIG)) begin
            err_sig_reg <= 3'h0;
        end
    end

    // ************************************************************
    // Row-write key decode
    // ************************************************************
    // Key bits arrive LSB first; shifting right leaves bit 0 as first received
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            key_shift_reg <= '0;
            key_cnt_reg <= 7'h00;
        end else if (KEY_END || !port_enabled) begin
            key_cnt_reg <= 7'h00;
        end else if (KEY_BIT_VALID) begin
            key_shift_reg <= {KEY_BIT, key_shift_reg[KEY_BITS_W-1:1]};
            key_cnt_reg <= key_cnt_reg + 7'h01;
        end
    end

    // Key flag: decode sets it (set wins), debugger write closes the session
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            key_flag_reg <= 1'b0;
        end else if (!port_enabled) begin
            key_flag_reg <= 1'b0;
        end else if (KEY_END && key_cnt_reg == 7'(KEY_BITS_W)
                     && key_shift_reg == dprw_pkg::ROW_KEY) begin
            key_flag_reg <= 1'b1;
        end else if (key_close_wr) begin
            key_flag_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Session state machine
    // ************************************************************
    // Remember a reset pulse raised while the key is held, start on release
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            reset_seen_reg <= 1'b0;
        end else if (!key_flag_reg) begin
            reset_seen_reg <= 1'b0;
        end else if (SYS_RESET_REQ) begin
            reset_seen_reg <= 1'b1;
        end else if (state_reg == DPRW_STAGE) begin
            reset_seen_reg <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg <= DPRW_IDLE;
        end else if (!key_flag_reg || !port_enabled) begin
            state_reg <= DPRW_IDLE;
        end else begin
            unique case (state_reg)
                DPRW_IDLE: begin
                    if (reset_seen_reg && !SYS_RESET_REQ) begin
                        state_reg <= DPRW_STAGE;
                    end
                end
                DPRW_STAGE: begin
                    if (done_wr) begin
                        state_reg <= DPRW_COPY;
                    end
                end
                DPRW_COPY: begin
                    if (ROW_COPY_DONE) begin
                        state_reg <= DPRW_IDLE;
                    end
                end
            endcase
        end
    end

    // One-shot copy trigger, only from a done write while staging
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ROW_COPY_START <= 1'b0;
        end else begin
            ROW_COPY_START <= state_reg == DPRW_STAGE && done_wr && key_flag_reg
                && port_enabled;
        end
    end

    // ************************************************************
    // Memory access gate
    // ************************************************************
    // Refuse reads and out-of-range writes in session, and any access with the clock stopped unless clock hold emulates sleep
    assign MEM_REFUSED = (MEM_REQ.wr || MEM_REQ.rd)
        && ((in_session && (MEM_REQ.rd || !row_ok))
            || SYS_CLK_STOPPED && !SLEEP_EMULATE);

    // Bus master: one access at a time, held until the system answers
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            bus_busy_reg <= 1'b0;
            BUS_WR <= 1'b0;
            BUS_RD <= 1'b0;
            BUS_ADDR <= 24'h000000;
            BUS_WDATA <= 8'h00;
            MEM_RDATA <= 8'h00;
            MEM_DONE <= 1'b0;
        end else begin
            MEM_DONE <= 1'b0;
            if (bus_busy_reg) begin
                if (BUS_READY) begin
                    bus_busy_reg <= 1'b0;
                    BUS_WR <= 1'b0;
                    BUS_RD <= 1'b0;
                    MEM_RDATA <= BUS_RDATA;
                    MEM_DONE <= 1'b1;
                end
            end else if ((MEM_REQ.wr || MEM_REQ.rd) && !MEM_REFUSED) begin
                bus_busy_reg <= 1'b1;
                BUS_WR <= MEM_REQ.wr;
                BUS_RD <= MEM_REQ.rd && !MEM_REQ.wr;
                BUS_ADDR <= MEM_REQ.addr;
                BUS_WDATA <= MEM_REQ.wdata;
            end
        end
    end

    // ************************************************************
    // Sync event; link logic never gated by sleep
    // ************************************************************
    dprw_sync3 u_sync (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .d(SYNC_PIN),
        .q(sync_q)
    );

    // Rising edge of the synchronised character gives a one-cycle level
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync_prev_reg <= 1'b0;
            SYNC_EVENT <= 1'b0;
        end else begin
            sync_prev_reg <= sync_q;
            SYNC_EVENT <= sync_q && !sync_prev_reg;
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 8'h00;
        end else if (REG_REQ.rd) begin
            unique case (REG_REQ.addr)
                dprw_pkg::OFS_REVISION: REG_RDATA <= dprw_pkg::REVISION_RESET;
                dprw_pkg::OFS_ERRSIG: REG_RDATA <= {5'h00, err_sig_reg};
                dprw_pkg::OFS_CTRL_PRI: REG_RDATA <= ctrl_pri_reg;
                dprw_pkg::OFS_CTRL_SEC: REG_RDATA <= ctrl_sec_reg;
                dprw_pkg::OFS_KEY_FLAGS: REG_RDATA <=
                    8'(key_flag_reg) << dprw_pkg::KEY_ROW_BIT;
                dprw_pkg::OFS_RST_REQ: REG_RDATA <= rst_req_reg;
                dprw_pkg::OFS_CLK_DIV: REG_RDATA <= clk_div_reg;
                dprw_pkg::OFS_SESS_CTRL: REG_RDATA <= {7'h00, clk_hold_reg};
                dprw_pkg::OFS_SYS_FLAGS: begin
                    REG_RDATA <= (SYS_FLAGS_OTHER
                        & ~((8'h01 << dprw_pkg::SYS_ASLEEP_BIT)
                        | (8'h01 << dprw_pkg::SYS_ROWSTART_BIT)))
                        | (8'(SYS_ASLEEP) << dprw_pkg::SYS_ASLEEP_BIT)
                        | (8'(row_start) << dprw_pkg::SYS_ROWSTART_BIT);
                end
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- verilog/dprw_sync3.sv ----
/*
 * Three-stage input synchroniser; the output changes once stages two and
 * three agree. Assumes an asynchronous input and one core clock.
 */
`timescale 1ns/10ps
`default_nettype none
module dprw_sync3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output var logic q
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Accept a new level only when the last two stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            q <= s3_reg;
        end
    end
endmodule
`default_nettype wire
